/* shared/dti_defines.vh */
/*
 Register offsets, field positions and timing constants for the dual timer block.
 Assumes a 4-bit register offset relative to the block's base.
*/
`ifndef DTI_DEFINES_VH
`define DTI_DEFINES_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DTI_OFS_T1_HI     4'h8
`define DTI_OFS_T1_LO     4'h9
`define DTI_OFS_CAP_HI    4'hA
`define DTI_OFS_CAP_LO    4'hB
`define DTI_OFS_T2_HI     4'hC
`define DTI_OFS_T2_LO     4'hD
`define DTI_OFS_TCTL      4'hE
`define DTI_OFS_INTCTL    4'hF
`define DTI_OFS_XYCTL     4'h6
`define DTI_OFS_PZCTL     4'h7
`define DTI_OFS_PXDATA    4'h0
`define DTI_OFS_PYDATA    4'h1
// ----------------------------------------------------------------------
// Timer control bits
// ----------------------------------------------------------------------
`define DTI_TC_T1_START   7
`define DTI_TC_T1_SRC     6
`define DTI_TC_T1_FREE    5
`define DTI_TC_T1_EXTEN   4
`define DTI_TC_T2_START   3
`define DTI_TC_T2_SRC     2
`define DTI_TC_T2_FREE    1
`define DTI_TC_T2_TRIG    0
// ----------------------------------------------------------------------
// Interrupt control bits
// ----------------------------------------------------------------------
`define DTI_IC_X_FLAG     7
`define DTI_IC_X_EN       6
`define DTI_IC_Y_FLAG     5
`define DTI_IC_Y_EN       4
`define DTI_IC_T1_FLAG    3
`define DTI_IC_T1_EN      2
`define DTI_IC_T2_FLAG    1
`define DTI_IC_T2_EN      0
// ----------------------------------------------------------------------
// Port Z control bits
// ----------------------------------------------------------------------
`define DTI_PZ_IRQ_EN     7
`define DTI_PZ_TIMER_EXT_CLOCK_PIN_EN    6
`define DTI_PZ_T2OUT_EN   5
`define DTI_PZ_FIRST_TIMER_OUTPUT_PIN_EN   4
`define DTI_PZ_Y_EN       2
`define DTI_PZ_X_EN       0
// ----------------------------------------------------------------------
// XY control bits: active edge polarity (1 = rising)
// ----------------------------------------------------------------------
`define DTI_XY_X_RISE     0
`define DTI_XY_Y_RISE     1
// ----------------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------------
`define DTI_PRESC_DIV     4
`define DTI_PRESC_LAST    2'h3
`define DTI_CNT_WRAP      16'h0000
`define DTI_ZERO8         8'h00
`define DTI_ZERO16        16'h0000
`endif

/* rtl/dti_timer.v */
/*
 Dual 16-bit down-counting timer with capture latch, toggling outputs and
 timer interrupt control. Assumes a plain synchronous register port
 (read data one cycle after the read strobe) and pins synchronous to mclk_i
 beyond the two-stage synchronisers placed here.
*/
// Summary of operation
// - Writing one to control bit 3 reloads timer 2 and starts it; retriggerable.
// - Time-out period equals decrementer clock period times latch value plus one.
// - Decrementer stepping from zero to all ones is the time-out and sets flag.
// - Free-run mode reloads the latch after every time-out and keeps counting.
// - Writing zero to a start bit stops that counter.
// - Internal source gives a decrementer clock of input clock divided by four.
// - External source: timer 2 counts Y handshake pulses, timer 1 external clock pin.
// - Timer 1 external enable halts counting while X input is non-active.
// - Trigger bit set: active X edge sets timer 2 start and starts it.
// - Only timer 1 has a capture latch.
// - Active Y edge copies timer 1 count into capture latch if Y enabled.
// - Output-select bit set gives a square wave toggling at each time-out.
// - Timer 2 drives its own output pin and reports through its own flag.
// - A time-out sets a timer flag only when that timer's enable bit is one.
// - With port Z bit 7 set, interrupt pin low while any enabled flag is one.
// - X and Y flags clear when host reads or writes their port data register.
// - Interrupt control bit layout; odd bits clear on write one, read as flags.
// - Reads at C and D return timer 2 current count, not latch.
// - Reading the count high byte latches the low byte for a consistent pair.
// - One-shot mode clears the start bit after the first time-out and stops.
// - Output goes low at start, high at first time-out, then toggles.
// - Control bit 2 selects timer 2 clock: zero divide by four, one Y handshake pulses.
`include "dti_defines.vh"
module dti_timer (
    input  wire       mclk_i,
    input  wire       sys_rst_i,
    input  wire       clk_en_i,
    input  wire [3:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    input  wire       x_handshake_input_i,
    input  wire       y_handshake_input_i,
    input  wire       timer_ext_clock_pin_i,
    output reg  [7:0] rdata_o,
    output reg        first_timer_output_pin_o,
    output reg        second_timer_output_pin_o,
    output reg        interrupt_request_pin_o,
    output reg        interrupt_request_pin_oe_o
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg  [15:0] latch [0:1];
    reg  [15:0] count [0:1];
    reg  [1:0]  start;
    reg  [1:0]  src;
    reg  [1:0]  free;
    reg         t1_exten;
    reg         t2_trig;
    reg  [7:0]  xy_ctl;
    reg  [7:0]  pz_ctl;
    reg  [15:0] capture;
    reg  [7:0]  low_hold [0:1];
    reg  [3:0]  int_en;
    reg  [3:0]  int_flag;
    reg  [1:0]  tout;
    reg  [1:0]  presc;
    reg  [2:0]  sync1;
    reg  [2:0]  sync2;
    reg  [2:0]  sync3;
    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    // Index 0 = X, 1 = Y, 2 = external clock pin
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
        end else if (clk_en_i) begin
            sync1 <= {timer_ext_clock_pin_i, y_handshake_input_i, x_handshake_input_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    wire x_rise = xy_ctl[`DTI_XY_X_RISE];
    wire y_rise = xy_ctl[`DTI_XY_Y_RISE];
    wire x_edge = x_rise ? (sync2[0] & ~sync3[0]) : (~sync2[0] & sync3[0]);
    wire y_edge = y_rise ? (sync2[1] & ~sync3[1]) : (~sync2[1] & sync3[1]);
    wire k_edge = sync2[2] & ~sync3[2];
    wire x_active = ~(sync2[0] ^ x_rise);
    // ------------------------------------------------------------------
    // Decrementer clock ticks
    // ------------------------------------------------------------------
    wire presc_tick = (presc == `DTI_PRESC_LAST);
    wire [1:0] ext_tick;
    assign ext_tick[0] = k_edge & pz_ctl[`DTI_PZ_TIMER_EXT_CLOCK_PIN_EN];
    assign ext_tick[1] = y_edge & pz_ctl[`DTI_PZ_Y_EN];
    wire [1:0] gate;
    assign gate[0] = ~t1_exten | x_active;
    assign gate[1] = 1'b1;
    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire w_t1ctl = wr_i && (addr_i == `DTI_OFS_CAP_HI);
    wire w_t2ctl = wr_i && (addr_i == `DTI_OFS_TCTL);
    wire w_int   = wr_i && (addr_i == `DTI_OFS_INTCTL);
    wire trig    = t2_trig && x_edge && pz_ctl[`DTI_PZ_X_EN];
    wire [1:0] wstart;
    wire [1:0] wstop;
    assign wstart[0] = w_t1ctl && wdata_i[`DTI_TC_T1_START];
    assign wstop[0]  = w_t1ctl && !wdata_i[`DTI_TC_T1_START];
    assign wstart[1] = (w_t2ctl && wdata_i[`DTI_TC_T2_START]) || trig;
    assign wstop[1]  = w_t2ctl && !wdata_i[`DTI_TC_T2_START] && !trig;
    wire [1:0] timeout;
    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_tmr
            wire tick = src[g] ? ext_tick[g] : presc_tick;
            assign timeout[g] = start[g] && !wstart[g] && gate[g] && tick &&
                                (count[g] == `DTI_CNT_WRAP);
            always @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    count[g] <= `DTI_ZERO16;
                    start[g] <= 1'b0;
                    tout[g]  <= 1'b0;
                end else if (clk_en_i) begin
                    if (wstart[g]) begin
                        count[g] <= latch[g];
                        start[g] <= 1'b1;
                        tout[g]  <= 1'b0;
                    end else if (wstop[g]) begin
                        count[g] <= latch[g];
                        start[g] <= 1'b0;
                    end else if (timeout[g]) begin
                        tout[g] <= ~tout[g];
                        if (free[g]) begin
                            count[g] <= latch[g];
                        end else begin
                            count[g] <= count[g] - 16'h0001;
                            start[g] <= 1'b0;
                        end
                    end else if (start[g] && gate[g] && tick) begin
                        count[g] <= count[g] - 16'h0001;
                    end
                end
            end
        end
    endgenerate
    // ------------------------------------------------------------------
    // Registers, flags, capture
    // ------------------------------------------------------------------
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch[0] <= `DTI_ZERO16;
            latch[1] <= `DTI_ZERO16;
            src      <= 2'h0;
            free     <= 2'h0;
            t1_exten <= 1'b0;
            t2_trig  <= 1'b0;
            xy_ctl   <= `DTI_ZERO8;
            pz_ctl   <= `DTI_ZERO8;
            capture  <= `DTI_ZERO16;
            int_en   <= 4'h0;
            int_flag <= 4'h0;
            presc    <= 2'h0;
            low_hold[0] <= `DTI_ZERO8;
            low_hold[1] <= `DTI_ZERO8;
        end else if (clk_en_i) begin
            presc <= presc + 2'h1;
            if (wr_i) begin
                if (addr_i == `DTI_OFS_T1_HI) begin
                    latch[0][15:8] <= wdata_i;
                end else if (addr_i == `DTI_OFS_T1_LO) begin
                    latch[0][7:0] <= wdata_i;
                end else if (addr_i == `DTI_OFS_T2_HI) begin
                    latch[1][15:8] <= wdata_i;
                end else if (addr_i == `DTI_OFS_T2_LO) begin
                    latch[1][7:0] <= wdata_i;
                end else if (addr_i == `DTI_OFS_CAP_HI) begin
                    src[0]   <= wdata_i[`DTI_TC_T1_SRC];
                    free[0]  <= wdata_i[`DTI_TC_T1_FREE];
                    t1_exten <= wdata_i[`DTI_TC_T1_EXTEN];
                end else if (addr_i == `DTI_OFS_TCTL) begin
                    src[1]  <= wdata_i[`DTI_TC_T2_SRC];
                    free[1] <= wdata_i[`DTI_TC_T2_FREE];
                    t2_trig <= wdata_i[`DTI_TC_T2_TRIG];
                end else if (addr_i == `DTI_OFS_XYCTL) begin
                    xy_ctl <= wdata_i;
                end else if (addr_i == `DTI_OFS_PZCTL) begin
                    pz_ctl <= wdata_i;
                end else if (addr_i == `DTI_OFS_INTCTL) begin
                    int_en <= {wdata_i[`DTI_IC_X_EN], wdata_i[`DTI_IC_Y_EN],
                               wdata_i[`DTI_IC_T1_EN], wdata_i[`DTI_IC_T2_EN]};
                end
            end
            if (rd_i && addr_i == `DTI_OFS_T1_HI) begin
                low_hold[0] <= count[0][7:0];
            end
            if (rd_i && addr_i == `DTI_OFS_T2_HI) begin
                low_hold[1] <= count[1][7:0];
            end
            if (y_edge && pz_ctl[`DTI_PZ_Y_EN]) begin
                capture <= count[0];
            end
            // Flag order {X, Y, T1, T2}; port data clears win over X/Y sets, sets win over write-one clears
            if ((rd_i || wr_i) && addr_i == `DTI_OFS_PXDATA) begin
                int_flag[3] <= 1'b0;
            end else if (x_edge && pz_ctl[`DTI_PZ_X_EN] && int_en[3]) begin
                int_flag[3] <= 1'b1;
            end else if (w_int && wdata_i[`DTI_IC_X_FLAG]) begin
                int_flag[3] <= 1'b0;
            end
            if ((rd_i || wr_i) && addr_i == `DTI_OFS_PYDATA) begin
                int_flag[2] <= 1'b0;
            end else if (y_edge && pz_ctl[`DTI_PZ_Y_EN] && int_en[2]) begin
                int_flag[2] <= 1'b1;
            end else if (w_int && wdata_i[`DTI_IC_Y_FLAG]) begin
                int_flag[2] <= 1'b0;
            end
            if (timeout[0] && int_en[1]) begin
                int_flag[1] <= 1'b1;
            end else if (w_int && wdata_i[`DTI_IC_T1_FLAG]) begin
                int_flag[1] <= 1'b0;
            end
            if (timeout[1] && int_en[0]) begin
                int_flag[0] <= 1'b1;
            end else if (w_int && wdata_i[`DTI_IC_T2_FLAG]) begin
                int_flag[0] <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------------
    // Read data and pins
    // ------------------------------------------------------------------
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = `DTI_ZERO8;
        if (addr_i == `DTI_OFS_T1_HI) begin
            next_rdata = count[0][15:8];
        end else if (addr_i == `DTI_OFS_T1_LO) begin
            next_rdata = low_hold[0];
        end else if (addr_i == `DTI_OFS_CAP_HI) begin
            next_rdata = capture[15:8];
        end else if (addr_i == `DTI_OFS_CAP_LO) begin
            next_rdata = capture[7:0];
        end else if (addr_i == `DTI_OFS_T2_HI) begin
            next_rdata = count[1][15:8];
        end else if (addr_i == `DTI_OFS_T2_LO) begin
            next_rdata = low_hold[1];
        end else if (addr_i == `DTI_OFS_TCTL) begin
            next_rdata = {start[0], src[0], free[0], t1_exten,
                          start[1], src[1], free[1], t2_trig};
        end else if (addr_i == `DTI_OFS_XYCTL) begin
            next_rdata = xy_ctl;
        end else if (addr_i == `DTI_OFS_PZCTL) begin
            next_rdata = pz_ctl;
        end else if (addr_i == `DTI_OFS_INTCTL) begin
            next_rdata = {int_flag[3], int_en[3], int_flag[2], int_en[2],
                          int_flag[1], int_en[1], int_flag[0], int_en[0]};
        end
    end
    wire irq = pz_ctl[`DTI_PZ_IRQ_EN] && |(int_flag & int_en);
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o                    <= `DTI_ZERO8;
            first_timer_output_pin_o   <= 1'b0;
            second_timer_output_pin_o  <= 1'b0;
            interrupt_request_pin_o    <= 1'b0;
            interrupt_request_pin_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            if (rd_i) begin
                rdata_o <= next_rdata;
            end
            // Outputs read low while deselected
            first_timer_output_pin_o   <= pz_ctl[`DTI_PZ_FIRST_TIMER_OUTPUT_PIN_EN] & tout[0];
            second_timer_output_pin_o  <= pz_ctl[`DTI_PZ_T2OUT_EN] & tout[1];
            interrupt_request_pin_oe_o <= irq;
        end
    end
endmodule

/* tb/dti_timer_monitor.sv */
/*
 Port-level checker for the dual timer block.
 Assumes a bind to dti_timer; it keeps its own copy of the host's port Z and interrupt control writes.
*/
`include "dti_defines.vh"
module dti_timer_monitor (
    input wire       mclk_i,
    input wire       sys_rst_i,
    input wire       clk_en_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire       x_handshake_input_i,
    input wire       y_handshake_input_i,
    input wire       timer_ext_clock_pin_i,
    input wire [7:0] rdata_o,
    input wire       first_timer_output_pin_o,
    input wire       second_timer_output_pin_o,
    input wire       interrupt_request_pin_o,
    input wire       interrupt_request_pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pz_sh;
    logic [7:0] ic_sh;
    logic       wr_ok;
    assign wr_ok = wr_i && clk_en_i;
    // Shadows only; the pins lag them by one more cycle
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pz_sh <= 8'h00;
            ic_sh <= 8'h00;
        end else begin
            if (wr_ok && addr_i == `DTI_OFS_PZCTL) pz_sh <= wdata_i;
            if (wr_ok && addr_i == `DTI_OFS_INTCTL) ic_sh <= wdata_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    t2_start_low_a: assert property (wr_ok && addr_i == `DTI_OFS_TCTL && wdata_i[3] && pz_sh[5]
        |-> ##2 !second_timer_output_pin_o) else $error("timer 2 pin not low at start");
    t1_start_low_a: assert property (wr_ok && addr_i == `DTI_OFS_CAP_HI && wdata_i[7] && pz_sh[4]
        |-> ##2 !first_timer_output_pin_o) else $error("timer 1 pin not low at start");
    t2_pin_gate_a: assert property (!pz_sh[5] && $past(!pz_sh[5]) |-> !second_timer_output_pin_o)
        else $error("timer 2 pin driven while deselected");
    t1_pin_gate_a: assert property (!pz_sh[4] && $past(!pz_sh[4]) |-> !first_timer_output_pin_o)
        else $error("timer 1 pin driven while deselected");
    irq_pin_gate_a: assert property (!pz_sh[7] && $past(!pz_sh[7]) |-> !interrupt_request_pin_oe_o)
        else $error("request asserted while disabled");
    irq_enable_gate_a: assert property ((ic_sh & 8'h55) == 8'h00 && $past((ic_sh & 8'h55) == 8'h00)
        |-> !interrupt_request_pin_oe_o) else $error("request with no source enabled");
    irq_low_value_a: assert property (!interrupt_request_pin_o)
        else $error("request pin value not low");
    unmapped_zero_a: assert property (rd_i && clk_en_i && addr_i inside {[4'h2:4'h5]}
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data changed without a read");
    freeze_out_a: assert property (!clk_en_i |=> $stable({first_timer_output_pin_o,
        second_timer_output_pin_o, interrupt_request_pin_oe_o})) else $error("outputs moved while frozen");
    cover property ($rose(second_timer_output_pin_o));
    cover property ($rose(first_timer_output_pin_o));
    cover property ($rose(interrupt_request_pin_oe_o));
endmodule

/* tb/dti_host.sv */
/*
 Host model: drives the plain register port of the timer block.
 Assumes read data stand in the cycle after the read strobe.
*/
module dti_host (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Idle address and data are inverted so stale values never look valid
    task write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge mclk_i);
        d = rdata_i;
    endtask
    // High byte first: it freezes the low byte for the second read
    task read_count(input logic [3:0] hi, output logic [15:0] v);
        read_reg(hi, v[15:8]);
        read_reg(hi + 4'h1, v[7:0]);
    endtask
endmodule

/* tb/dti_timer_tb_top.sv */
/*
 Self-checking bench for the dual timer block.
 Assumes a 250 MHz clock and the host model for all register traffic.
*/
`include "dti_defines.vh"
module dti_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, sys_rst_i, clk_en_i, x_in, y_in, wr, rd, t1p, t2p, irq, oe;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, b;
    logic [15:0] v;
    integer err_total, tests_run, seed, tl, per, c;
    dti_host host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    dti_timer dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .x_handshake_input_i(x_in),
        .y_handshake_input_i(y_in), .timer_ext_clock_pin_i(1'b0), .rdata_o(rdata),
        .first_timer_output_pin_o(t1p), .second_timer_output_pin_o(t2p),
        .interrupt_request_pin_o(irq), .interrupt_request_pin_oe_o(oe));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_total = err_total + 1;
        end
    endtask
    task chk_cyc(input string nm, input integer e, input integer g);
        tests_run = tests_run + 1;
        if (g != e) begin
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
            err_total = err_total + 1;
        end
    endtask
    task wait_tog(input bit t2, input integer lim, output integer n);
        logic p;
        p = t2 ? t2p : t1p;
        n = 0;
        while (n < lim && (t2 ? t2p : t1p) === p) begin
            @(posedge mclk_i);
            n = n + 1;
        end
    endtask
    // ----------------------------------------------------------------------
    // Free-run timing, flag, clear and stop for one timer
    // ----------------------------------------------------------------------
    task run_free(input bit t2);
        logic [3:0] hi;
        hi = t2 ? `DTI_OFS_T2_HI : `DTI_OFS_T1_HI;
        tl = 3 + ($random(seed) & 15);
        per = 4 * (tl + 1);
        host.write_reg(hi, 8'h00);
        host.write_reg(hi + 4'h1, tl[7:0]);
        host.write_reg(t2 ? `DTI_OFS_TCTL : `DTI_OFS_CAP_HI, t2 ? 8'h0A : 8'hA0);
        repeat (2) @(posedge mclk_i);
        chk("pin at start", 16'h0, {15'h0, t2 ? t2p : t1p});
        wait_tog(t2, per + 8, c);
        chk("pin first timeout", 16'h1, {15'h0, t2 ? t2p : t1p});
        wait_tog(t2, per + 8, c);
        chk_cyc("period", per, c);
        chk("request", 16'h1, {15'h0, oe});
        host.read_reg(`DTI_OFS_INTCTL, b);
        chk("flags", {8'h0, t2 ? 8'h07 : 8'h0D}, {8'h0, b});
        host.read_count(hi, v);
        chk("count range", 16'h1, {15'h0, v <= tl});
        // Stop first so no new time-out can race the clear
        host.write_reg(t2 ? `DTI_OFS_TCTL : `DTI_OFS_CAP_HI, 8'h00);
        host.write_reg(`DTI_OFS_INTCTL, t2 ? 8'h07 : 8'h0D);
        host.read_reg(`DTI_OFS_INTCTL, b);
        chk("flags cleared", 16'h0005, {8'h0, b});
        chk("request released", 16'h0, {15'h0, oe});
        host.read_count(hi, v);
        chk("stopped count", tl[15:0], v);
        wait_tog(t2, per + 8, c);
        chk_cyc("no timeout stopped", per + 8, c);
        $display("free run test done, timer %0d", t2 ? 2 : 1);
    endtask
    initial begin
        err_total = 0;
        tests_run = 0;
        seed = 32'h6a54b30d;
        sys_rst_i = 1'b1;
        clk_en_i = 1'b1;
        x_in = 1'b0;
        y_in = 1'b0;
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        host.read_reg(`DTI_OFS_INTCTL, b);
        chk("control reset", 16'h0, {8'h0, b});
        host.read_reg(4'h3, b);
        chk("unmapped read", 16'h0, {8'h0, b});
        $display("reset test done");
        host.write_reg(`DTI_OFS_PZCTL, 8'hB0);
        host.write_reg(`DTI_OFS_INTCTL, 8'h05);
        run_free(1'b0);
        run_free(1'b1);
        // One-shot with the enable off: no flag, start self-clears
        host.write_reg(`DTI_OFS_INTCTL, 8'h00);
        host.write_reg(`DTI_OFS_TCTL, 8'h08);
        // Let the start force the pin low before watching for the time-out
        repeat (2) @(posedge mclk_i);
        wait_tog(1'b1, per + 8, c);
        host.read_reg(`DTI_OFS_TCTL, b);
        chk("one shot start", 16'h0, {8'h0, b});
        host.read_count(`DTI_OFS_T2_HI, v);
        chk("one shot count", 16'hFFFF, v);
        host.read_reg(`DTI_OFS_INTCTL, b);
        chk("masked flag", 16'h0, {8'h0, b});
        wait_tog(1'b1, per + 8, c);
        chk_cyc("one shot halts", per + 8, c);
        $display("one shot test done");
        host.write_reg(`DTI_OFS_PZCTL, 8'hB1);
        host.write_reg(`DTI_OFS_XYCTL, 8'h01);
        host.write_reg(`DTI_OFS_TCTL, 8'h01);
        @(posedge mclk_i);
        x_in <= 1'b1;
        repeat (8) @(posedge mclk_i);
        host.read_reg(`DTI_OFS_TCTL, b);
        chk("trigger start", 16'h0009, {8'h0, b});
        clk_en_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        clk_en_i <= 1'b1;
        host.write_reg(`DTI_OFS_TCTL, 8'h00);
        $display("trigger test done");
        // Capture of a stopped timer 1 count on a rising Y edge
        host.write_reg(`DTI_OFS_T1_HI, 8'h00);
        host.write_reg(`DTI_OFS_T1_LO, 8'h5A);
        host.write_reg(`DTI_OFS_CAP_HI, 8'h00);
        host.write_reg(`DTI_OFS_PZCTL, 8'h84);
        host.write_reg(`DTI_OFS_XYCTL, 8'h02);
        @(posedge mclk_i);
        y_in <= 1'b1;
        repeat (8) @(posedge mclk_i);
        host.read_count(`DTI_OFS_CAP_HI, v);
        chk("capture", 16'h005A, v);
        $display("capture test done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total = err_total + 1;
        $display("[FAIL] watchdog expected end seen hang");
        finish_test();
    end
    task finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
endmodule
bind dti_timer dti_timer_monitor mon (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .x_handshake_input_i(x_handshake_input_i), .y_handshake_input_i(y_handshake_input_i),
    .timer_ext_clock_pin_i(timer_ext_clock_pin_i), .rdata_o(rdata_o),
    .first_timer_output_pin_o(first_timer_output_pin_o),
    .second_timer_output_pin_o(second_timer_output_pin_o),
    .interrupt_request_pin_o(interrupt_request_pin_o),
    .interrupt_request_pin_oe_o(interrupt_request_pin_oe_o));
